/* hw/vpr_pwm_div.sv */
// Holds the shared package and the chopper period divider.
// Assumes one clock, pclk, and an asynchronous active-low reset, presetn.
package vpr_pkg;
  // Register byte addresses on the APB bus.
  localparam logic [11:0] VPR_ADDR_CTRL = 12'h000;
  localparam logic [11:0] VPR_ADDR_CFG  = 12'h004;
  localparam logic [11:0] VPR_ADDR_CUR  = 12'h008;
  localparam logic [11:0] VPR_ADDR_STAT = 12'h00c;
  localparam logic [11:0] VPR_ADDR_AMP  = 12'h010;
  // Field positions.
  localparam int VPR_CFG_GRAD_LSB  = 8;
  localparam int VPR_CUR_HOLD_LSB  = 8;
  localparam int VPR_CUR_GSC_LSB   = 16;
  localparam int VPR_STAT_SCA_LSB  = 16;
  localparam int VPR_STAT_AT1_DONE = 28;
  localparam int VPR_STAT_HALF     = 29;
  localparam int VPR_STAT_AT1      = 30;
  localparam int VPR_STAT_AT2      = 31;
  // Reset values.
  localparam logic [11:0] VPR_CTRL_RST = 12'h153;
  localparam logic [7:0]  VPR_OFS_RST  = 8'h1e;
  localparam logic [7:0]  VPR_GRAD_RST = 8'h00;
  localparam logic [4:0]  VPR_RUN_RST  = 5'h10;
  localparam logic [4:0]  VPR_HOLD_RST = 5'h08;
  localparam logic [7:0]  VPR_GSC_RST  = 8'h00;
  // Chopper period in half clocks for each frequency code.
  localparam logic [10:0] VPR_PER_00 = 11'h400;
  localparam logic [10:0] VPR_PER_01 = 11'h2ab;
  localparam logic [10:0] VPR_PER_10 = 11'h200;
  localparam logic [10:0] VPR_PER_11 = 11'h19a;
  // Blanking time in clocks for each blanking code.
  localparam logic [9:0] VPR_BLK_00 = 10'h010;
  localparam logic [9:0] VPR_BLK_01 = 10'h018;
  localparam logic [9:0] VPR_BLK_10 = 10'h024;
  localparam logic [9:0] VPR_BLK_11 = 10'h036;
  // Tuning counts.
  localparam logic [4:0] VPR_SETTLE_N  = 5'h10;
  localparam logic [3:0] VPR_UNREACH_N = 4'h8;
  localparam logic [2:0] VPR_FS_PER_GRAD = 3'h7;
  localparam logic [7:0] VPR_ERR_TOL   = 8'h02;

  typedef struct packed {
    logic [3:0] gain;
    logic [1:0] blanking_time_select;
    logic [1:0] freq;
    logic       rsv;
    logic       freewheel;
    logic       autograd;
    logic       autoscale;
  } vpr_ctrl_t;

  typedef struct packed {
    logic       chop_on;
    logic       period_start;
    logic [7:0] amplitude;
  } vpr_drive_t;
endpackage

module vpr_pwm_div (
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Settings.
  input  wire logic [1:0]   freq_sel,
  input  wire logic         half_freq,
  input  wire logic [7:0]   duty,
  // Period timing.
  output logic              per_start,
  output logic              on_phase,
  output logic [9:0]        on_cnt
);
  import vpr_pkg::*;

  logic [10:0] acc_q, acc_d, per_q, per_d, per_sel;
  logic [9:0]  cnt_q, cnt_d;
  logic [18:0] on_len;
  logic        wrap;

  // Accumulate two half clocks per cycle, one when halved, so the mean rate is exactly 2/N, or 1/N when halved.
  always_comb begin
    case (freq_sel) // RULE_10
      2'b00:   per_sel = VPR_PER_00;
      2'b01:   per_sel = VPR_PER_01;
      2'b10:   per_sel = VPR_PER_10;
      default: per_sel = VPR_PER_11;
    endcase
    acc_d = acc_q + (half_freq ? 11'h001 : 11'h002);
    wrap  = (acc_d >= per_q);
    per_d = per_q;
    cnt_d = cnt_q + 10'h001;
    if (wrap) begin
      acc_d = acc_d - per_q;
      per_d = per_sel; // RULE_22
      cnt_d = 10'h000;
    end
    on_len = (19'(duty) * 19'(per_q)) >> 9;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 11'h000;
      per_q <= VPR_PER_00;
      cnt_q <= 10'h000;
    end else begin
      acc_q <= acc_d;
      per_q <= per_d;
      cnt_q <= cnt_d;
    end
  end

  assign per_start = (cnt_q == 10'h000);
  assign on_phase  = (19'(cnt_q) < on_len);
  assign on_cnt    = cnt_q;

  // Helper count of cycles between two period starts.
  logic [9:0] gap_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_q <= 10'h000;
    else if (per_start) gap_q <= 10'h001;
    else gap_q <= gap_q + 10'h001;
  end

  a_period_full: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
    (per_start && $past(per_start, 1) == 1'b0 && per_q == VPR_PER_10 && !half_freq
     && $past(per_q) == VPR_PER_10 && !$past(half_freq)) |-> gap_q == 10'h100)
    else $error("chopper period wrong for code 10");
endmodule

/* hw/vpr_regulator.sv */
// Voltage-mode chopper amplitude regulator with automatic tuning, APB slave.
// Assumes pclk at 10 MHz, inputs synchronous to pclk, a current sampler outside.
// How it works
// RULE_01: Gradient tuning starts only after standstill offset tuning has completed.
// RULE_02: Standstill completion may need several stops; settling restarts each time.
// RULE_03: Controller confirms tuning by watching the correction value fall to zero.
// RULE_04: Controller steps slowly, velocity 8 or less, at least ten steps.
// RULE_05: Writing the gradient setting also seeds the tuned gradient.
// RULE_06: Scaler or supply change invalidates tuning until standstill tuning reruns.
// RULE_07: Tuning reruns whenever its standstill or moving conditions hold again.
// RULE_08: Autoscale and autograd select feedback mode; autoscale zero selects feed-forward.
// RULE_09: Feed-forward mode ignores current samples entirely.
// RULE_10: Frequency code selects clock times 2/1024, 2/683, 2/512 or 2/410.
// RULE_11: Controller picks a code giving roughly 20 to 50 kHz.
// RULE_12: Current sampled in on time drives a proportional regulator with set gain.
// RULE_13: Controller keeps regulator gain small, often one.
// RULE_14: No sample when on time is shorter than blanking, bounding minimum current.
// RULE_15: Reduced currents scale from tuned values, or programmed ones in feed-forward.
// RULE_16: Freewheeling forces zero amplitude.
// RULE_17: Unreachable current during standstill tuning halves the chopper frequency.
// RULE_18: Halved frequency holds while standstill and current scale equals run current.
// RULE_19: Controller sets run current above the regulation limit during tuning.
// RULE_20: Controller holds motor still at run current to start standstill tuning.
// RULE_21: Moving tuning changes the gradient by one per eight full steps.
// RULE_22: New frequency code takes effect at the next period start.
//
// Chosen here: the address map and the APB slave port.
module vpr_regulator (
  // Clock and reset.
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave.
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Motion and sensing.
  input  wire logic                   standstill,
  input  wire logic [7:0]             velocity,
  input  wire logic                   full_step,
  input  wire logic [7:0]             current_sample,
  input  wire logic                   supply_change,
  // Bridge drive.
  output vpr_pkg::vpr_drive_t         drive
);
  import vpr_pkg::*;

  vpr_ctrl_t   ctrl_q, ctrl_d;
  logic [7:0]  ofs_set_q, ofs_set_d, grad_set_q, grad_set_d, gsc_q, gsc_d;
  logic [4:0]  run_q, run_d, hold_q, hold_d;
  logic [31:0] prdata_q, prdata_d;
  logic        wr_en, rd_setup, mapped;

  // APB decode; the slave never inserts wait states.
  always_comb begin
    mapped   = (paddr == VPR_ADDR_CTRL) || (paddr == VPR_ADDR_CFG) ||
               (paddr == VPR_ADDR_CUR) || (paddr == VPR_ADDR_STAT) ||
               (paddr == VPR_ADDR_AMP);
    wr_en    = psel && penable && pwrite && mapped;
    rd_setup = psel && !penable && !pwrite;
  end
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_q;

  // Chopper timing and regulator state.
  logic [7:0]  tofs_q, tofs_d, tgrad_q, tgrad_d, amp_q, amp_d;
  logic signed [8:0] sca_q, sca_d;
  logic        at1_done_q, at1_done_d, half_q, half_d, sampled_q, sampled_d;
  logic [4:0]  settle_q, settle_d;
  logic [3:0]  unreach_q, unreach_d;
  logic [2:0]  fs_q, fs_d;
  logic        per_start, on_phase;
  logic [9:0]  on_cnt, blank;
  logic        auto_mode, at1_cond, at2_cond, take;
  logic [4:0]  cs;
  logic [8:0]  gsc_eff, base, sum9;
  logic [15:0] target_w;
  logic [7:0]  target;
  logic signed [9:0]  err;
  logic signed [14:0] delta;
  logic signed [15:0] sca_w;
  logic [10:0] scaled;
  logic signed [12:0] amp_raw;
  logic [7:0]  ofs_use, grad_use;

  vpr_pwm_div u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .freq_sel  (ctrl_q.freq),
    .half_freq (half_q),
    .duty      (amp_q),
    .per_start (per_start),
    .on_phase  (on_phase),
    .on_cnt    (on_cnt)
  );

  // Register writes; a new gradient setting also seeds the tuned gradient.
  always_comb begin
    ctrl_d     = ctrl_q;
    ofs_set_d  = ofs_set_q;
    grad_set_d = grad_set_q;
    run_d      = run_q;
    hold_d     = hold_q;
    gsc_d      = gsc_q;
    if (wr_en && paddr == VPR_ADDR_CTRL) ctrl_d = pwdata[11:0];
    if (wr_en && paddr == VPR_ADDR_CFG) begin
      ofs_set_d  = pwdata[7:0];
      grad_set_d = pwdata[VPR_CFG_GRAD_LSB +: 8];
    end
    if (wr_en && paddr == VPR_ADDR_CUR) begin
      run_d  = pwdata[4:0];
      hold_d = pwdata[VPR_CUR_HOLD_LSB +: 5];
      gsc_d  = pwdata[VPR_CUR_GSC_LSB +: 8];
    end
    prdata_d = prdata_q;
    if (rd_setup) begin
      case (paddr)
        VPR_ADDR_CTRL: prdata_d = {20'h00000, ctrl_q};
        VPR_ADDR_CFG:  prdata_d = {16'h0000, grad_set_q, ofs_set_q};
        VPR_ADDR_CUR:  prdata_d = {8'h00, gsc_q, 3'h0, hold_q, 3'h0, run_q};
        VPR_ADDR_STAT: prdata_d = {at2_cond, at1_cond, half_q, at1_done_q, 3'h0,
                                   sca_q, tgrad_q, tofs_q};
        VPR_ADDR_AMP:  prdata_d = {24'h000000, amp_q};
        default:       prdata_d = 32'h00000000;
      endcase
    end
  end

  // Current scale, target and tuning conditions.
  always_comb begin
    auto_mode = ctrl_q.autoscale && ctrl_q.autograd; // RULE_08
    cs        = standstill ? hold_q : run_q;
    gsc_eff   = (gsc_q == 8'h00) ? 9'h100 : {1'b0, gsc_q};
    target_w  = (16'(cs) + 16'h0001) * 16'(gsc_eff) >> 5;
    target    = (target_w > 16'h00ff) ? 8'hff : target_w[7:0];
    at1_cond  = auto_mode && standstill && (cs == run_q); // RULE_07
    ofs_use   = auto_mode ? tofs_q : ofs_set_q; // RULE_15
    grad_use  = auto_mode ? tgrad_q : grad_set_q; // RULE_15
    base      = 9'(ofs_use) + 9'((16'(grad_use) * 16'(velocity)) >> 8);
    scaled    = 11'((16'(base) * (16'(cs) + 16'h0001)) >> 5); // RULE_15
    sum9      = (scaled > 11'h1ff) ? 9'h1ff : scaled[8:0];
    at2_cond  = auto_mode && !standstill && at1_done_q && // RULE_01
                (10'(sum9) * 10'h002 > 10'(tofs_q) * 10'h003) &&
                (10'(sum9) < 10'(tofs_q) * 10'h004) && (sum9 < 9'h0ff);
    case (ctrl_q.blanking_time_select)
      2'b00:   blank = VPR_BLK_00;
      2'b01:   blank = VPR_BLK_01;
      2'b10:   blank = VPR_BLK_10;
      default: blank = VPR_BLK_11;
    endcase
  end

  // Sampling, proportional regulation and tuning.
  always_comb begin
    take  = auto_mode && on_phase && !sampled_q && (on_cnt == blank); // RULE_14 RULE_09
    err   = 10'(target) - 10'(current_sample);
    // Signed product, so that a current above target pulls the correction down.
    delta = (15'(err) * $signed(15'(ctrl_q.gain))) >>> 3;
    sampled_d  = per_start ? 1'b0 : (sampled_q || take);
    sca_d      = sca_q;
    tofs_d     = tofs_q;
    tgrad_d    = tgrad_q;
    at1_done_d = at1_done_q;
    half_d     = half_q;
    settle_d   = settle_q;
    unreach_d  = unreach_q;
    fs_d       = fs_q;
    sca_w      = 16'(sca_q) + 16'(delta);
    if (take) begin // RULE_12
      if (sca_w > 16'sd255) sca_d = 9'sd255;
      else if (sca_w < -16'sd255) sca_d = -9'sd255;
      else sca_d = sca_w[8:0];
    end
    if (!auto_mode) sca_d = 9'sd0; // RULE_09
    // Standstill phase: fold the correction into the tuned offset.
    if (at1_cond && per_start) begin
      if (sca_q > 9'sd0 && tofs_q != 8'hff) begin
        tofs_d = tofs_q + 8'h01;
        sca_d  = sca_q - 9'sd1;
      end else if (sca_q < 9'sd0 && tofs_q != 8'h00) begin
        tofs_d = tofs_q - 8'h01;
        sca_d  = sca_q + 9'sd1;
      end
      if (sca_q == 9'sd0 && (err <= $signed(10'(VPR_ERR_TOL))) &&
          (err >= -$signed(10'(VPR_ERR_TOL)))) begin
        if (settle_q == VPR_SETTLE_N) at1_done_d = 1'b1; // RULE_02
        else settle_d = settle_q + 5'h01;
      end else begin
        settle_d = 5'h00;
      end
    end
    if (!at1_cond) settle_d = 5'h00; // RULE_02
    // Unreachable current in standstill tuning halves the chopper rate.
    if (at1_cond && take && err > 10'sd0 && amp_q == 8'hff) begin // RULE_17
      if (unreach_q == VPR_UNREACH_N) half_d = 1'b1;
      else unreach_d = unreach_q + 4'h1;
    end
    if (!at1_cond) begin // RULE_18
      half_d    = 1'b0;
      unreach_d = 4'h0;
    end
    // Moving phase: one gradient count per eight full steps.
    if (at2_cond && full_step) begin // RULE_21
      fs_d = fs_q + 3'h1;
      if (fs_q == VPR_FS_PER_GRAD) begin
        if (sca_q > 9'sd0 && tgrad_q != 8'hff) tgrad_d = tgrad_q + 8'h01;
        else if (sca_q < 9'sd0 && tgrad_q != 8'h00) tgrad_d = tgrad_q - 8'h01;
      end
    end
    if (wr_en && paddr == VPR_ADDR_CFG) begin // RULE_05
      tgrad_d = pwdata[VPR_CFG_GRAD_LSB +: 8];
      tofs_d  = pwdata[7:0];
    end
    // Settling restarts too, so an invalidated result needs a full standstill run again.
    if (supply_change || (wr_en && paddr == VPR_ADDR_CUR &&
        pwdata[VPR_CUR_GSC_LSB +: 8] != gsc_q)) begin // RULE_06
      at1_done_d = 1'b0;
      settle_d   = 5'h00;
    end
    amp_raw = 13'(scaled) + 13'(sca_q);
    if (ctrl_q.freewheel) amp_d = 8'h00; // RULE_16
    else if (amp_raw < 13'sd0) amp_d = 8'h00;
    else if (amp_raw > 13'sd255) amp_d = 8'hff;
    else amp_d = amp_raw[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= VPR_CTRL_RST;
      ofs_set_q  <= VPR_OFS_RST;
      grad_set_q <= VPR_GRAD_RST;
      run_q      <= VPR_RUN_RST;
      hold_q     <= VPR_HOLD_RST;
      gsc_q      <= VPR_GSC_RST;
      prdata_q   <= 32'h00000000;
      tofs_q     <= VPR_OFS_RST;
      tgrad_q    <= VPR_GRAD_RST;
      sca_q      <= 9'sd0;
      amp_q      <= 8'h00;
      at1_done_q <= 1'b0;
      half_q     <= 1'b0;
      sampled_q  <= 1'b0;
      settle_q   <= 5'h00;
      unreach_q  <= 4'h0;
      fs_q       <= 3'h0;
    end else begin
      ctrl_q     <= ctrl_d;
      ofs_set_q  <= ofs_set_d;
      grad_set_q <= grad_set_d;
      run_q      <= run_d;
      hold_q     <= hold_d;
      gsc_q      <= gsc_d;
      prdata_q   <= prdata_d;
      tofs_q     <= tofs_d;
      tgrad_q    <= tgrad_d;
      sca_q      <= sca_d;
      amp_q      <= amp_d;
      at1_done_q <= at1_done_d;
      half_q     <= half_d;
      sampled_q  <= sampled_d;
      settle_q   <= settle_d;
      unreach_q  <= unreach_d;
      fs_q       <= fs_d;
    end
  end

  // Only the amplitude is registered; the chopper phase and the period start follow the divider.
  assign drive.chop_on      = on_phase && !ctrl_q.freewheel;
  assign drive.period_start = per_start;
  assign drive.amplitude    = amp_q;

  a_grad_needs_at1: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    ($changed(tgrad_q) && !$past(wr_en)) |-> $past(at1_done_q))
    else $error("gradient tuned before standstill tuning done");
  a_grad_eight_steps: assert property (@(posedge pclk) disable iff (!presetn) // RULE_21
    ($changed(tgrad_q) && !$past(wr_en)) |-> ($past(full_step) && $past(fs_q) == 3'h7))
    else $error("gradient changed off an eighth full step");
  a_invalid_tuning: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    supply_change |=> !at1_done_q)
    else $error("tuning still valid after supply change");
  a_ff_no_meas: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    (!ctrl_q.autoscale ##1 !ctrl_q.autoscale) |-> sca_q == 9'sd0)
    else $error("feed-forward mode used current correction");
  a_half_only_at1: assert property (@(posedge pclk) disable iff (!presetn) // RULE_17
    $rose(half_q) |-> $past(at1_cond) && $past(amp_q) == 8'hff)
    else $error("half rate entered outside standstill tuning");
  a_half_drops: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
    (half_q && !at1_cond) |=> !half_q)
    else $error("half rate kept outside standstill at run current");
  a_freewheel_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE_16
    ctrl_q.freewheel [*2] |-> amp_q == 8'h00 && !drive.chop_on)
    else $error("freewheel left amplitude on");
  a_one_sample: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
    (take && !per_start) |=> !take [*3])
    else $error("more than one current sample per period");
  a_settle_restart: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    !at1_cond |=> settle_q == 5'h00)
    else $error("standstill settling kept across motion");
endmodule

/* verif/tb.sv */
// Self-checking bench for the chopper amplitude regulator.
// Assumes the motion model file is compiled before this one.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import vpr_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, a0;
  logic        standstill, full_step, supply_change, move, stall, fast;
  logic [7:0]  velocity, current_sample;
  vpr_drive_t  drive;
  int          fails, n_compared, cyc, n;
  int          per[4] = '{1024, 683, 512, 410};

  vpr_regulator u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .standstill(standstill), .velocity(velocity),
    .full_step(full_step), .current_sample(current_sample),
    .supply_change(supply_change), .drive(drive));

  vpr_motion_model u_motion (.pclk(pclk), .presetn(presetn), .move(move), .stall(stall),
    .fast(fast),
    .drive(drive), .standstill(standstill), .velocity(velocity), .full_step(full_step),
    .current_sample(current_sample));

  // Free-running 10 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Cut a hang short well above the longest expected tuning time.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 16) chk("pready", 32'h1, 32'h0);
  endtask

  // Poll one status bit until it reaches the wanted level or the read budget runs out.
  task automatic wait_bit(input int b, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      apb(1'b0, VPR_ADDR_STAT, 32'h0);
      if (rd[b] === v) break;
    end
  endtask

  // Clocks spanned by two chopper periods, counted from the next period start.
  task automatic two_periods(output int p);
    int k;
    k = 0;
    p = 0;
    while (drive.period_start !== 1'b1 && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    repeat (2) begin
      do begin
        @(posedge pclk);
        p++;
      end while (drive.period_start !== 1'b1 && p < 5000);
    end
  endtask

  task automatic pulse_supply;
    @(posedge pclk);
    supply_change <= 1'b1;
    @(posedge pclk);
    supply_change <= 1'b0;
  endtask

  task automatic t_regs;
    apb(1'b0, VPR_ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'(VPR_CTRL_RST), rd);
    apb(1'b0, VPR_ADDR_CFG, 32'h0);
    chk("cfg reset", {16'h0, VPR_GRAD_RST, VPR_OFS_RST}, rd);
    apb(1'b0, VPR_ADDR_CUR, 32'h0);
    chk("cur reset", {8'h0, VPR_GSC_RST, 3'h0, VPR_HOLD_RST, 3'h0, VPR_RUN_RST}, rd);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, VPR_ADDR_CFG, 32'h0000221e);
    apb(1'b0, VPR_ADDR_STAT, 32'h0);
    chk("seeded gradient", 32'h22, 32'(rd[15:8]));
    apb(1'b1, VPR_ADDR_CFG, 32'h0000001e);
  endtask

  // Motion before standstill tuning completes must leave the gradient alone.
  task automatic t_gate;
    move <= 1'b1;
    repeat (24 * 64) @(posedge pclk);
    apb(1'b0, VPR_ADDR_STAT, 32'h0);
    chk("gradient untouched", 32'h0, 32'(rd[15:8]));
    chk("moving tuning idle", 32'h0, 32'(rd[31]));
    move <= 1'b0;
  endtask

  task automatic t_freq;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, VPR_ADDR_CTRL, 32'h100 | 32'(c << 4));
      two_periods(n);
      two_periods(n);
      chk("chopper period", 32'(per[c]), 32'(n));
    end
  endtask

  // Feed-forward mode keeps its amplitude while the coil current collapses.
  task automatic t_ff;
    apb(1'b1, VPR_ADDR_CTRL, 32'h130);
    stall <= 1'b1;
    apb(1'b0, VPR_ADDR_AMP, 32'h0);
    a0 = rd;
    repeat (3) two_periods(n);
    apb(1'b0, VPR_ADDR_AMP, 32'h0);
    chk("ff amplitude steady", a0, rd);
    apb(1'b0, VPR_ADDR_STAT, 32'h0);
    chk("ff correction", 32'h0, 32'(rd[24:16]));
    chk("ff no tuning", 32'h0, 32'(rd[30]));
    stall <= 1'b0;
  endtask

  task automatic t_free;
    int hits;
    hits = 0;
    apb(1'b1, VPR_ADDR_CTRL, 32'h134);
    two_periods(n);
    repeat (410) begin
      @(posedge pclk);
      if (drive.chop_on !== 1'b0) hits++;
    end
    chk("freewheel on time", 32'h0, 32'(hits));
    apb(1'b0, VPR_ADDR_AMP, 32'h0);
    chk("freewheel amplitude", 32'h0, rd);
  endtask

  task automatic t_tune;
    // Scaler 128 puts the tuned offset near 128; the seed keeps the amplitude above blanking.
    apb(1'b1, VPR_ADDR_CUR, 32'h00801010);
    apb(1'b1, VPR_ADDR_CFG, 32'h00000070);
    apb(1'b1, VPR_ADDR_CTRL, 32'h433);
    for (int t = 0; t < 2; t++) begin
      wait_bit(28, 1'b1, 8000);
      if (rd[28] === 1'b1) break;
      move <= 1'b1;
      repeat (256) @(posedge pclk);
      move <= 1'b0;
    end
    chk("standstill tuning done", 32'h1, 32'(rd[28]));
    chk("correction settled", 32'h0, 32'(rd[24:16]));
    pulse_supply();
    apb(1'b0, VPR_ADDR_STAT, 32'h0);
    chk("done after supply change", 32'h0, 32'(rd[28]));
    wait_bit(28, 1'b1, 8000);
    chk("tuning rerun", 32'h1, 32'(rd[28]));
  endtask

  // Moving tuning at full run current walks the gradient down while the correction is negative.
  task automatic t_grad;
    apb(1'b1, VPR_ADDR_CUR, 32'h0080101f);
    apb(1'b0, VPR_ADDR_STAT, 32'h0);
    apb(1'b1, VPR_ADDR_CFG, {16'h0000, 8'h60, rd[7:0]});
    fast <= 1'b1;
    move <= 1'b1;
    repeat (16 * 64 + 32) @(posedge pclk);
    apb(1'b0, VPR_ADDR_STAT, 32'h0);
    chk("moving tuning active", 32'h1, 32'(rd[31]));
    chk("gradient tuned", 32'h5e, 32'(rd[15:8]));
    move <= 1'b0;
    fast <= 1'b0;
    apb(1'b1, VPR_ADDR_CUR, 32'h00801010);
  endtask

  // An unreachable target during standstill tuning halves the chopper rate.
  task automatic t_half;
    pulse_supply();
    apb(1'b1, VPR_ADDR_CFG, 32'h000000ff);
    stall <= 1'b1;
    wait_bit(29, 1'b1, 1500);
    chk("half rate entered", 32'h1, 32'(rd[29]));
    two_periods(n);
    two_periods(n);
    chk("half rate period", 32'd820, 32'(n));
    move <= 1'b1;
    wait_bit(29, 1'b0, 400);
    chk("half rate left", 32'h0, 32'(rd[29]));
    move <= 1'b0;
    stall <= 1'b0;
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    supply_change = 1'b0;
    move = 1'b0;
    stall = 1'b0;
    fast = 1'b0;
    fails = 0;
    n_compared = 0;
    cyc = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_gate();
    t_freq();
    t_ff();
    t_free();
    t_tune();
    t_grad();
    t_half();
    print_verdict();
  end
endmodule

/* verif/vpr_motion_model.sv */
// Model of the motion controller and coil that face the chopper regulator.
// Assumes the bench commands move, fast and stall; all are synchronous to pclk.
module vpr_motion_model (
  // Clock and reset.
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Commands from the bench.
  input  wire logic                move,
  input  wire logic                stall,
  input  wire logic                fast,
  // Bridge drive seen by the coil.
  input  wire vpr_pkg::vpr_drive_t drive,
  // Motion and sensing.
  output logic                     standstill,
  output logic [7:0]               velocity,
  output logic                     full_step,
  output logic [7:0]               current_sample
);
  timeunit 1ns;
  timeprecision 1ns;
  import vpr_pkg::*;

  logic [5:0] step_cnt_q;
  logic [5:0] step_cnt_d;

  // Step slowly, one full step per 64 clocks, so standstill tuning sees clean stops.
  always_comb begin
    step_cnt_d = move ? step_cnt_q + 6'h01 : 6'h00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt_q <= 6'h00;
    end else begin
      step_cnt_q <= step_cnt_d;
    end
  end

  // The motor is held still whenever no motion is commanded.
  assign full_step  = move && (step_cnt_q == 6'h3f);
  // Fast motion gives enough back EMF for moving tuning; slow motion suits standstill tuning.
  assign velocity   = !move ? 8'h00 : (fast ? 8'hc0 : 8'h08);
  assign standstill = !move;
  // A stalled coil never reaches its target, which the regulator has to notice.
  assign current_sample = stall ? 8'h00 : drive.amplitude;
endmodule
